// *** core/vfsr_ctrl.sv ***
// Purpose: Control side of a video smoothing filter: resets and shadow regs
// Assumes: One clock, synchronous active-low reset, AHB-Lite slave, OKAY only
// Notes: Stream datapath lives elsewhere; this block gates its valid/ready
`timescale 1ns/100ps
module vfsr_ctrl
    import vfsr_pkg::*;
#(
    parameter int RESET_CYCLES = vfsr_pkg::FSYNC_RESET_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic inSof,
    input wire logic inValid,
    input wire logic inReady,
    input wire logic inLast,
    input wire logic outValid,
    input wire logic outReady,
    output logic coreReset,
    output logic fifoFlush,
    output logic procEnable,
    output logic forceLow,
    output logic [31:0] strengthActive,
    output logic [31:0] sizeActive
);
    import vfsr_pkg::*;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    // ==========================================================
    // Bus address phase capture
    logic wrPend_q, wrPend_d, rdPend_q, rdPend_d;
    logic [11:0] addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] control_q, control_d;
    vfsr_fr_state_type frState_q, frState_d;
    logic [5:0] frCount_q, frCount_d;
    logic inFrame_q, inFrame_d;
    logic waitSof_q, waitSof_d;
    logic softReset, commitNow, wrStrength, wrSize, sofBeat, eofBeat;
    logic [31:0] strengthHold, sizeHold;

    assign sofBeat = inSof && inValid && inReady;
    assign eofBeat = inLast && inValid && inReady && !inSof;

    // Accept single word transfers; data phase is always one cycle
    always_comb begin
        wrPend_d = 1'b0;
        rdPend_d = 1'b0;
        addr_d = addr_q;
        if (hsel && hready && htrans == HTRANS_NONSEQ && hsize == HSIZE_WORD) begin
            wrPend_d = hwrite;
            rdPend_d = !hwrite;
            addr_d = haddr[11:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            wrPend_q <= wrPend_d;
            rdPend_q <= rdPend_d;
            addr_q <= addr_d;
        end
    end

    // ==========================================================
    // Control register: enable, commit permission, fsync call, reset flag
    always_comb begin
        control_d = control_q;
        if (wrPend_q && hit(addr_q, OFF_CONTROL)) begin
            control_d = hwdata;
        end
        // Fsync request bit is a call: cleared when the sequencer takes it
        if (frState_q != FR_IDLE) control_d[CTL_FSYNC_BIT] = 1'b0;
        // Fsync reset also restores control, but not while a new write lands
        if (frState_q == FR_HOLD && frCount_q == 6'h00 && !wrPend_q) begin
            control_d = CONTROL_RESET;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) control_q <= CONTROL_RESET;
        else control_q <= control_d;
    end

    // ==========================================================
    // Frame tracking and frame-boundary reset sequencer
    always_comb begin
        inFrame_d = inFrame_q;
        if (sofBeat) inFrame_d = !(inLast && inValid);
        else if (eofBeat) inFrame_d = 1'b0;
        frState_d = frState_q;
        frCount_d = frCount_q;
        case (frState_q)
            FR_IDLE: begin
                if (control_q[CTL_FSYNC_BIT]) begin
                    // Idle stream: apply at once, else wait for frame end
                    // A closing beat in this very cycle counts as frame end,
                    // otherwise the call would sit until the next frame
                    frState_d = (inFrame_q && !eofBeat) ? FR_WAIT : FR_HOLD;
                    frCount_d = 6'(RESET_CYCLES - 1);
                end
            end
            FR_WAIT: begin
                // A stalled stream keeps us here; new SOF also ends the frame
                if (eofBeat || sofBeat) frState_d = FR_HOLD;
            end
            FR_HOLD: begin
                if (frCount_q == 6'h00) frState_d = FR_IDLE;
                else frCount_d = frCount_q - 6'h01;
            end
            default: frState_d = FR_IDLE;
        endcase
        if (softReset) inFrame_d = 1'b0;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            frState_q <= FR_IDLE;
            frCount_q <= 6'h00;
            inFrame_q <= 1'b0;
        end else begin
            frState_q <= frState_d;
            frCount_q <= frCount_d;
            inFrame_q <= inFrame_d;
        end
    end

    // ==========================================================
    // Reset combine and resync after release
    assign softReset = control_q[CTL_RESET_BIT] || frState_q == FR_HOLD;

    always_comb begin
        waitSof_d = waitSof_q;
        if (softReset) waitSof_d = 1'b1;
        else if (sofBeat) waitSof_d = 1'b0;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) waitSof_q <= 1'b0;
        else waitSof_q <= waitSof_d;
    end

    // Commit all shadow pairs on one SOF strobe, gated by permission
    assign commitNow = sofBeat && control_q[CTL_COMMIT_BIT] && !softReset;
    assign wrStrength = wrPend_q && hit(addr_q, OFF_STRENGTH);
    assign wrSize = wrPend_q && hit(addr_q, OFF_ACTIVE_SIZE);

    vfsr_shadow_pair #(.WIDTH(32), .RESET_VALUE(STRENGTH_RESET)) uStrength (
        .clock(clock),
        .rst_n(rst_n),
        .softReset(softReset),
        .load(wrStrength),
        .loadData(hwdata),
        .commit(commitNow),
        .holdValue(strengthHold),
        .activeValue(strengthActive)
    );

    vfsr_shadow_pair #(.WIDTH(32), .RESET_VALUE(SIZE_RESET)) uSize (
        .clock(clock),
        .rst_n(rst_n),
        .softReset(softReset),
        .load(wrSize),
        .loadData(hwdata),
        .commit(commitNow),
        .holdValue(sizeHold),
        .activeValue(sizeActive)
    );

    // ==========================================================
    // Read data: registered in the address phase's following cycle
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (rdPend_d) begin
            case (haddr[11:0])
                OFF_CONTROL: rdata_d = control_q;
                OFF_STATUS: rdata_d = {28'h0000000, waitSof_q, inFrame_q,
                                       frState_q != FR_IDLE, softReset};
                OFF_STRENGTH: rdata_d = strengthHold;
                OFF_ACTIVE_SIZE: rdata_d = sizeHold;
                OFF_STRENGTH_RB: rdata_d = strengthActive;
                OFF_ACTIVE_SIZE_RB: rdata_d = sizeActive;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) rdata_q <= 32'h0000_0000;
        else rdata_q <= rdata_d;
    end

    assign hrdata = rdata_q;
    assign hreadyout = 1'b1; // Zero wait states
    assign hresp = 1'b0; // Always OKAY

    // ==========================================================
    // Stream-side controls
    assign coreReset = softReset;
    assign fifoFlush = softReset;
    assign forceLow = softReset || waitSof_q;
    assign procEnable = control_q[CTL_ENABLE_BIT] && !forceLow;

    // Output handshake observed only by the datapath
    logic unusedOut;
    assign unusedOut = outValid & outReady;
endmodule : vfsr_ctrl

// *** core/vfsr_pkg.sv ***
// Purpose: Constants for the video filter shadow/reset control block
// Assumes: 32-bit AHB-Lite register bus, single 200 MHz clock
// Notes: Offsets are byte addresses of aligned words
package vfsr_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [11:0] OFF_CONTROL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_ACTIVE_SIZE = 12'h020;
    localparam logic [11:0] OFF_STRENGTH = 12'h100;
    localparam logic [11:0] OFF_ACTIVE_SIZE_RB = 12'h024;
    localparam logic [11:0] OFF_STRENGTH_RB = 12'h104;
    // ==========================================================
    // Control bit positions
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_COMMIT_BIT = 1;
    localparam int CTL_FSYNC_BIT = 29;
    localparam int CTL_RESET_BIT = 30;
    // ==========================================================
    // Reset values and timing
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] SIZE_RESET = 32'h0000_0000;
    localparam logic [31:0] STRENGTH_RESET = 32'h0000_0000;
    localparam int CLOCK_MHZ = 200;
    localparam int FSYNC_RESET_CYCLES = 32;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // Frame-synchronised reset sequencer states
    typedef enum logic [1:0] {FR_IDLE, FR_WAIT, FR_HOLD} vfsr_fr_state_type;
endpackage : vfsr_pkg

// *** core/vfsr_shadow_pair.sv ***
// Purpose: Holding and active copy of one double-buffered parameter
// Assumes: Load and commit strobes from the control core
// Notes: Soft reset restores both copies
`timescale 1ns/100ps
module vfsr_shadow_pair #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic softReset,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadData,
    input wire logic commit,
    output logic [WIDTH-1:0] holdValue,
    output logic [WIDTH-1:0] activeValue
);
    logic [WIDTH-1:0] hold_q, hold_d, act_q, act_d;

    // ==========================================================
    // Next values: write hits holding copy only, commit copies over
    always_comb begin
        hold_d = hold_q;
        act_d = act_q;
        if (softReset) begin
            hold_d = RESET_VALUE;
            act_d = RESET_VALUE;
        end else begin
            if (load) hold_d = loadData;
            if (commit) act_d = hold_q;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hold_q <= RESET_VALUE;
            act_q <= RESET_VALUE;
        end else begin
            hold_q <= hold_d;
            act_q <= act_d;
        end
    end

    assign holdValue = hold_q;
    assign activeValue = act_q;
endmodule : vfsr_shadow_pair

// *** verif/vfsr_ctrl_assertions.sv ***
// Purpose: Port-level checks for vfsr_ctrl
// Assumes: One clock, sync active-low reset
// Notes: Soft reset may restore active copies
`timescale 1ns/100ps
module vfsr_ctrl_assertions
    import vfsr_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic inSof,
    input wire logic inValid,
    input wire logic inReady,
    input wire logic coreReset,
    input wire logic fifoFlush,
    input wire logic procEnable,
    input wire logic forceLow,
    input wire logic [31:0] strengthActive,
    input wire logic [31:0] sizeActive
);
    // ==========================================================
    // Sequences
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence sofBeat; inSof && inValid && inReady; endsequence
    sequence resetEnd; coreReset ##1 !coreReset; endsequence
    // ==========================================================
    // Properties
    a_bus_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus answer not zero-wait OKAY");
    a_rdata_idle: assert property (!(hsel && hready && htrans == HTRANS_NONSEQ && !hwrite)
        |=> hrdata == 32'h0000_0000) else $error("read data outside data phase");
    a_flush_tracks: assert property (fifoFlush == coreReset)
        else $error("flush differs from core reset");
    a_reset_holds: assert property (coreReset |-> forceLow && !procEnable)
        else $error("stream not held low in reset");
    a_enable_gate: assert property (procEnable |-> !forceLow)
        else $error("enabled while held");
    a_resync_wait: assert property (resetEnd |-> forceLow)
        else $error("no wait for frame start");
    a_resync_stay: assert property (forceLow && !coreReset && !(inSof && inValid && inReady)
        |=> forceLow) else $error("resumed without frame start");
    a_resync_sof: assert property (sofBeat ##0 (forceLow && !coreReset) |=> !forceLow || coreReset)
        else $error("frame start did not resume");
    a_commit_sof: assert property ($changed(strengthActive) || $changed(sizeActive)
        |-> $past(inSof && inValid && inReady) || $past(coreReset))
        else $error("active copy moved off frame start");
endmodule : vfsr_ctrl_assertions

// *** verif/vfsr_stream_src.sv ***
// Purpose: Upstream video source, fixed-length frames
// Assumes: Sink always ready
// Notes: Sideband toggles while not valid
`timescale 1ns/100ps
module vfsr_stream_src #(
    parameter int LEN = 8
) (
    input wire logic clock,
    input wire logic go,
    input wire logic hold,
    output logic inSof,
    output logic inValid,
    output logic inLast,
    output logic busy
);
    int beat = -1;
    logic tog = 1'b0;
    // ==========================================================
    // Beat counter; hold stalls mid-frame
    always @(posedge clock) begin
        tog <= ~tog;
        if (inValid)
            beat <= (beat == LEN - 1) ? -1 : beat + 1;
        else if (go && beat < 0)
            beat <= 0;
    end
    // Sideband is junk outside valid beats
    assign busy = beat >= 0;
    assign inValid = busy && !hold;
    assign inSof = inValid ? beat == 0 : tog;
    assign inLast = inValid ? beat == LEN - 1 : ~tog;
endmodule : vfsr_stream_src

// *** verif/vfsr_ctrl_tb_top.sv ***
// Purpose: Register and reset sequence tests for vfsr_ctrl
// Assumes: AHB-Lite single word transfers
// Notes: Stream sink always ready
`timescale 1ns/100ps
module vfsr_ctrl_tb_top;
    import vfsr_pkg::*;
    logic clock = 0, rst_n = 0, hsel = 0, hwrite = 0, inReady = 1, go = 0, hold = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, strengthActive, sizeActive, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic hreadyout, hresp, inSof, inValid, inLast, busy, coreReset, fifoFlush;
    logic procEnable, forceLow;
    int bad_count = 0, compares = 0, cnt;
    vfsr_ctrl i_dut (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .inSof, .inValid, .inReady,
        .inLast, .outValid(1'b0), .outReady(1'b1), .coreReset, .fifoFlush, .procEnable,
        .forceLow, .strengthActive, .sizeActive);
    vfsr_stream_src i_src (.clock, .go, .hold, .inSof, .inValid, .inLast, .busy);
    // ==========================================================
    // Clock and tasks
    initial forever #2.5 clock = ~clock;
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One whole-word transfer; waits on hready, never a fixed count
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1;
        haddr <= {20'h00000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= HSIZE_WORD;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task rdc(input logic [11:0] a, input logic [31:0] e);
        ahb(0, a, 0);
        chk("hrdata", rd, e);
    endtask : rdc
    task frame();
        go <= 1;
        @(posedge clock);
        go <= 0;
        @(posedge clock);
        for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clock);
        @(posedge clock);
    endtask : frame
    // Length of the next core reset pulse
    task rlen();
        cnt = 0;
        for (int i = 0; i < 300 && coreReset !== 1'b1; i++) @(posedge clock);
        while (coreReset === 1'b1 && cnt < 100) begin
            cnt++;
            @(posedge clock);
        end
    endtask : rlen
    task print_verdict();
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // ==========================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1;
        @(posedge clock);
        rdc(OFF_CONTROL, CONTROL_RESET);
        ahb(1, 12'h008, 32'hFFFF_FFFF);
        rdc(12'h008, 32'h0000_0000);
        ahb(1, OFF_CONTROL, 32'h0000_0001);
        ahb(1, OFF_STRENGTH, 32'h0000_0055);
        ahb(1, OFF_ACTIVE_SIZE, 32'h0000_0A0B);
        rdc(OFF_STRENGTH, 32'h0000_0055);
        rdc(OFF_ACTIVE_SIZE, 32'h0000_0A0B);
        frame();
        chk("strengthActive", strengthActive, STRENGTH_RESET);
        chk("sizeActive", sizeActive, SIZE_RESET);
        chk("procEnable", procEnable, 1'b1);
        ahb(1, OFF_CONTROL, 32'h0000_0003);
        frame();
        chk("strengthActive", strengthActive, 32'h0000_0055);
        chk("sizeActive", sizeActive, 32'h0000_0A0B);
        rdc(OFF_STRENGTH_RB, 32'h0000_0055);
        rdc(OFF_ACTIVE_SIZE_RB, 32'h0000_0A0B);
        ahb(1, OFF_CONTROL, 32'h0000_0002);
        @(posedge clock);
        chk("procEnable", procEnable, 1'b0);
        // Frame-boundary reset while idle, then stalled mid-frame
        ahb(1, OFF_CONTROL, 32'h2000_0003);
        rlen();
        chk("resetLen", cnt, FSYNC_RESET_CYCLES);
        rdc(OFF_CONTROL, CONTROL_RESET);
        chk("sizeActive", sizeActive, SIZE_RESET);
        chk("forceLow", forceLow, 1'b1);
        frame();
        chk("forceLow", forceLow, 1'b0);
        go <= 1;
        @(posedge clock);
        go <= 0;
        repeat (3) @(posedge clock);
        hold <= 1;
        ahb(1, OFF_CONTROL, 32'h2000_0000);
        repeat (40) @(posedge clock);
        chk("coreReset", coreReset, 1'b0);
        hold <= 0;
        rlen();
        chk("resetLen", cnt, FSYNC_RESET_CYCLES);
        frame();
        // Immediate reset in mid-frame, held until cleared
        go <= 1;
        @(posedge clock);
        go <= 0;
        ahb(1, OFF_CONTROL, 32'h4000_0001);
        @(posedge clock);
        chk("coreReset", coreReset, 1'b1);
        repeat (40) @(posedge clock);
        chk("coreReset", coreReset, 1'b1);
        rdc(OFF_STATUS, 32'h0000_0009);
        ahb(1, OFF_CONTROL, 32'h0000_0000);
        @(posedge clock);
        chk("coreReset", coreReset, 1'b0);
        chk("forceLow", forceLow, 1'b1);
        frame();
        chk("forceLow", forceLow, 1'b0);
        print_verdict();
    end
    // Hang guard, 20000 cycles, far beyond the expected run of roughly 270 cycles
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        print_verdict();
    end
endmodule : vfsr_ctrl_tb_top
bind vfsr_ctrl vfsr_ctrl_assertions i_chk (.clock, .rst_n, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .inSof, .inValid, .inReady, .coreReset, .fifoFlush,
    .procEnable, .forceLow, .strengthActive, .sizeActive);
